// ==== core/dcra_channel.sv ====
/*
 * one measuring channel: counts own pulses and times the angle against the concurrent input.
 * assumes single-cycle pulse strobes synchronous to i_ref_clk and a shared 2 MHz tick enable.
 */
`timescale 1ns/100ps
`include "dcra_regs.svh"

module dcra_channel #(
    parameter int unsigned UPD_GAP = `DCRA_UPD_GAP_TICKS,
    parameter int unsigned ANGLE_LIMIT = `DCRA_ANGLE_LIMIT
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_tick,
    input wire logic i_own_pulse,
    input wire logic i_conc_pulse,
    output dcra_pkg::dcra_result_t o_result,
    output logic o_event
);

    ////////////////////////////////////////////////////////////////////////////////
    dcra_pkg::dcra_state_t state;
    dcra_pkg::dcra_state_t next_state;
    logic [15:0] pulse_cnt;
    logic [16:0] angle_cnt;
    logic [23:0] gap_cnt;
    logic seen_own;

    localparam logic [16:0] ANGLE_MAX = 17'(ANGLE_LIMIT);
    localparam logic [23:0] GAP_MAX = 24'(UPD_GAP);

    // ratio saturation is not done: above 65535 the value wraps and is undefined
    wire [15:0] next_pulse_cnt = pulse_cnt + 16'h0001;
    wire angle_slow = (angle_cnt >= ANGLE_MAX) || !seen_own;
    wire gap_ok = (gap_cnt >= GAP_MAX);
    wire do_update = i_conc_pulse && (state == dcra_pkg::DCRA_RUN) && gap_ok;
    wire angle_hold = angle_cnt[16] || (angle_cnt[15:0] == 16'hffff);

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        case (state)
            dcra_pkg::DCRA_IDLE: begin
                // first concurrent pulse only arms; the second opens the counting window (no enable needed)
                if (i_conc_pulse) begin
                    next_state = dcra_pkg::DCRA_ARMED;
                end
            end
            dcra_pkg::DCRA_ARMED: begin
                if (i_conc_pulse) begin
                    next_state = dcra_pkg::DCRA_RUN;
                end
            end
            dcra_pkg::DCRA_RUN: next_state = dcra_pkg::DCRA_RUN;
            default: next_state = dcra_pkg::DCRA_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state <= dcra_pkg::DCRA_IDLE;
        end else begin
            state <= (state == dcra_pkg::DCRA_ARMED && i_conc_pulse) ? dcra_pkg::DCRA_RUN
                : next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pulse count between concurrent pulses; window restarts on every concurrent pulse
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            pulse_cnt <= 16'h0000;
        end else if (i_conc_pulse) begin
            pulse_cnt <= {15'h0000, i_own_pulse};
        end else if (i_own_pulse) begin
            pulse_cnt <= next_pulse_cnt;
        end
    end

    // angle timer restarts on each own pulse, counts 0.5 us ticks
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            angle_cnt <= 17'h00000;
            seen_own <= 1'b0;
        end else if (i_own_pulse) begin
            angle_cnt <= 17'h00000;
            seen_own <= 1'b1;
        end else if (i_tick && !angle_hold) begin
            angle_cnt <= angle_cnt + 17'h00001;
        end
    end

    // spacing of updates so no more than ten results per second
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            gap_cnt <= 24'h000000;
        end else if (do_update) begin
            gap_cnt <= 24'h000000;
        end else if (i_tick && !gap_ok) begin
            gap_cnt <= gap_cnt + 24'h000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_result <= '0;
            o_event <= 1'b0;
        end else begin
            o_event <= do_update;
            if (do_update) begin
                o_result.ratio <= pulse_cnt;
                o_result.status[`DCRA_ST_RATIO_VALID] <= 1'b1;
                if (angle_slow) begin
                    o_result.angle <= `DCRA_FORCED_ANGLE;
                    o_result.status[`DCRA_ST_ANGLE_VALID] <= 1'b0;
                end else begin
                    o_result.angle <= angle_cnt[15:0];
                    o_result.status[`DCRA_ST_ANGLE_VALID] <= 1'b1;
                end
            end
        end
    end

endmodule : dcra_channel

// ==== core/dcra_pkg.sv ====
/*
 * types of the dual channel ratio and angle unit.
 * assumes dcra_regs.svh is on the include path.
 */
`include "dcra_regs.svh"

package dcra_pkg;

    typedef struct packed {
        logic [15:0] ratio;
        logic [15:0] angle;
        logic [1:0] status;
    } dcra_result_t;

    typedef enum logic [1:0] {
        DCRA_IDLE = 2'b00,
        DCRA_ARMED = 2'b01,
        DCRA_RUN = 2'b10
    } dcra_state_t;

endpackage : dcra_pkg

// ==== core/dcra_regs.svh ====
/*
 * constants of the dual channel ratio and angle unit: timing counts and status bit positions.
 * assumes a 40 MHz reference clock; included by the package and the design modules.
 */
//
// Behaviour
// - each of the two channels gets a ratio and an angle measured against the other channel.
// - ratio and angle of a channel are updated together on concurrent pulses, at most ten per second.
// - the status word of a channel holds separate validity flags for ratio and angle.
// - an event pulse marks each result update, in which ratio and angle are written together.
// - measurement runs continuously with no configuration or enable.
// - results are meaningful only while the concurrent frequency does not exceed the channel's.
// - ratio is the number of channel pulses between two consecutive concurrent pulses.
// - angle is the time from the last channel pulse to the next concurrent pulse.
// - one angle unit is half a microsecond.
// - angle is computed only above 40 Hz, otherwise it is forced to 65535.
`ifndef DCRA_REGS_SVH
`define DCRA_REGS_SVH

`define DCRA_CLK_HZ 40000000
`define DCRA_TICK_HZ 2000000
`define DCRA_TICK_DIV (`DCRA_CLK_HZ / `DCRA_TICK_HZ)
// 40 Hz -> 25 ms -> 50000 ticks of 0.5 us
`define DCRA_MIN_FREQ_HZ 40
`define DCRA_ANGLE_LIMIT (`DCRA_TICK_HZ / `DCRA_MIN_FREQ_HZ)
// 10 updates per second -> 100 ms between updates
`define DCRA_MAX_UPD_HZ 10
`define DCRA_UPD_GAP_TICKS (`DCRA_TICK_HZ / `DCRA_MAX_UPD_HZ)
`define DCRA_FORCED_ANGLE 16'hffff
`define DCRA_ST_RATIO_VALID 0
`define DCRA_ST_ANGLE_VALID 1

`endif

// ==== core/dcra_top.sv ====
/*
 * dual channel ratio and angle unit: two channels, each measured against the other.
 * assumes pulse inputs are one-cycle strobes already synchronous to the 40 MHz clock.
 */
`timescale 1ns/100ps
`include "dcra_regs.svh"

module dcra_top #(
    parameter int unsigned TICK_DIV = `DCRA_TICK_DIV,
    parameter int unsigned UPD_GAP = `DCRA_UPD_GAP_TICKS,
    parameter int unsigned ANGLE_LIMIT = `DCRA_ANGLE_LIMIT
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_pulse_a,
    input wire logic i_pulse_b,
    output dcra_pkg::dcra_result_t o_result_a,
    output dcra_pkg::dcra_result_t o_result_b,
    output logic o_event_a,
    output logic o_event_b
);

    ////////////////////////////////////////////////////////////////////////////////
    // 2 MHz tick enable shared by both channels
    logic [7:0] div_cnt;
    localparam logic [7:0] DIV_LAST = 8'(TICK_DIV - 1);
    wire tick = (div_cnt == DIV_LAST);

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // symmetric pair; results hold meaning only if concurrent rate <= own rate
    dcra_channel #(.UPD_GAP(UPD_GAP), .ANGLE_LIMIT(ANGLE_LIMIT)) u_chan_a (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_tick(tick),
        .i_own_pulse(i_pulse_a),
        .i_conc_pulse(i_pulse_b),
        .o_result(o_result_a),
        .o_event(o_event_a)
    );

    dcra_channel #(.UPD_GAP(UPD_GAP), .ANGLE_LIMIT(ANGLE_LIMIT)) u_chan_b (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_tick(tick),
        .i_own_pulse(i_pulse_b),
        .i_conc_pulse(i_pulse_a),
        .o_result(o_result_b),
        .o_event(o_event_b)
    );

endmodule : dcra_top

// ==== dv/dcra_props.sv ====
/* port checker of the ratio and angle unit.
   bound to dcra_top; sees only its ports. */
`timescale 1ns/100ps
module dcra_props #(
    parameter int unsigned ANGLE_LIMIT = 100
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_pulse_a,
    input wire logic i_pulse_b,
    input dcra_pkg::dcra_result_t o_result_a,
    input dcra_pkg::dcra_result_t o_result_b,
    input wire logic o_event_a,
    input wire logic o_event_b
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_upd_a;
        $past(i_pulse_b) && o_event_a;
    endsequence
    ////////////////////////////////////////
    chk_ev_a_cause: assert property (o_event_a |-> $past(i_pulse_b))
        else $error("event a without pulse b");
    chk_ev_b_cause: assert property (o_event_b |-> $past(i_pulse_a))
        else $error("event b without pulse a");
    chk_ev_a_single: assert property (s_upd_a |=> !o_event_a)
        else $error("event a longer than one cycle");
    // the clear done by a reset shows up on the edge that releases it
    chk_res_a_hold: assert property ($changed(o_result_a) && $past(i_rst_n) |-> o_event_a)
        else $error("result a changed without event");
    chk_res_b_hold: assert property ($changed(o_result_b) && $past(i_rst_n) |-> o_event_b)
        else $error("result b changed without event");
    chk_ratio_valid: assert property (s_upd_a |-> o_result_a.status[0])
        else $error("ratio a not valid on update");
    chk_angle_forced: assert property (s_upd_a and !o_result_a.status[1] |->
        o_result_a.angle == 16'hffff)
        else $error("invalid angle a not forced");
    chk_angle_range: assert property (s_upd_a and o_result_a.status[1] |->
        o_result_a.angle < ANGLE_LIMIT)
        else $error("valid angle a out of range");
endmodule : dcra_props
bind dcra_top dcra_props #(.ANGLE_LIMIT(ANGLE_LIMIT)) u_props (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_pulse_a(i_pulse_a), .i_pulse_b(i_pulse_b),
    .o_result_a(o_result_a), .o_result_b(o_result_b), .o_event_a(o_event_a),
    .o_event_b(o_event_b));

// ==== dv/dcra_sensors.sv ====
/* two pulse sensors giving one-cycle strobes.
   driven by bench tasks; lines change just after a rising edge. */
`timescale 1ns/100ps
module dcra_sensors (
    input wire logic i_ref_clk,
    output logic o_pulse_a,
    output logic o_pulse_b
);
    initial begin
        o_pulse_a = 1'b0;
        o_pulse_b = 1'b0;
    end
    // n back to back strobes; small n keeps the ratio far below 16 bits
    task automatic fire(input logic sel, input int n);
        @(posedge i_ref_clk);
        o_pulse_a <= !sel;
        o_pulse_b <= sel;
        repeat (n) @(posedge i_ref_clk);
        o_pulse_a <= 1'b0;
        o_pulse_b <= 1'b0;
    endtask : fire
endmodule : dcra_sensors

// ==== dv/tb_top.sv ====
/* self-checking bench of the ratio and angle unit.
   assumes the sensor model and the bound port checker. */
`timescale 1ns/100ps
module tb_top;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic pa;
    logic pb;
    logic ea;
    logic eb;
    dcra_pkg::dcra_result_t ra;
    dcra_pkg::dcra_result_t rb;
    int fail_count = 0;
    int samples_checked = 0;
    always #12.5 i_ref_clk = ~i_ref_clk;
    dcra_sensors sens (.i_ref_clk(i_ref_clk), .o_pulse_a(pa), .o_pulse_b(pb));
    // short gap and limit so the forced angle is reached in 2000 cycles
    dcra_top #(.TICK_DIV(20), .UPD_GAP(20), .ANGLE_LIMIT(100)) uut (.i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n), .i_pulse_a(pa), .i_pulse_b(pb), .o_result_a(ra),
        .o_result_b(rb), .o_event_a(ea), .o_event_b(eb));
    ////////////////////////////////////////
    task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done
    // concurrent strobe, then look at the cycle after it is sampled
    task automatic conc(input logic s, input logic ev, input logic [15:0] rt);
        dcra_pkg::dcra_result_t r;
        sens.fire(!s, 1);
        #1;
        r = s ? rb : ra;
        check("event", {15'h0, s ? eb : ea}, {15'h0, ev});
        if (ev) check("ratio", r.ratio, rt);
    endtask : conc
    ////////////////////////////////////////
    task automatic t_ratio(input logic s);
        dcra_pkg::dcra_result_t r;
        @(posedge i_rst_n);
        sens.fire(!s, 1);
        sens.fire(s, 2);
        repeat (500) @(posedge i_ref_clk);
        conc(s, 1'b0, 16'h0);
        repeat (50) @(posedge i_ref_clk);
        sens.fire(s, 3);
        repeat (98) @(posedge i_ref_clk);
        conc(s, 1'b1, 16'h3);
        r = s ? rb : ra;
        check("status", {14'h0, r.status}, 16'h3);
        check("angle", 16'(r.angle inside {[16'h4:16'h6]}), 16'h1);
        $display("ratio test done on channel %0d", s);
    endtask : t_ratio
    task automatic t_gap(input logic s);
        dcra_pkg::dcra_result_t r;
        repeat (100) @(posedge i_ref_clk);
        conc(s, 1'b0, 16'h0);
        sens.fire(s, 2);
        repeat (500) @(posedge i_ref_clk);
        conc(s, 1'b1, 16'h2);
        r = s ? rb : ra;
        check("angle ok", 16'(r.angle inside {[16'h18:16'h1a]}), 16'h1);
        $display("gap test done on channel %0d", s);
    endtask : t_gap
    task automatic t_forced(input logic s);
        dcra_pkg::dcra_result_t r;
        sens.fire(s, 1);
        repeat (2100) @(posedge i_ref_clk);
        conc(s, 1'b1, 16'h1);
        r = s ? rb : ra;
        check("forced", r.angle, 16'hffff);
        check("flags", {14'h0, r.status}, 16'h1);
        $display("forced angle test done on channel %0d", s);
    endtask : t_forced
    ////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        fail_count++;
        $display("watchdog expired");
        test_done();
    end
    initial begin
        for (int s = 0; s < 2; s++) begin
            @(posedge i_ref_clk);
            i_rst_n <= 1'b0;
            repeat (2) @(posedge i_ref_clk);
            i_rst_n <= 1'b1;
            t_ratio(s[0]);
            t_gap(s[0]);
            t_forced(s[0]);
        end
        test_done();
    end
endmodule : tb_top
